// ---- pkg/reconfig_ctl_pkg.sv ----
// Constants and types shared by the reconfiguration control front-end
package reconfig_ctl_pkg;

  // Register word offsets
  localparam logic [2:0] OFS_ACTION   = 3'h0;
  localparam logic [2:0] OFS_IMG_WR   = 3'h1;
  localparam logic [2:0] OFS_RD_REQ   = 3'h2;
  localparam logic [2:0] OFS_BUSY     = 3'h3;
  localparam logic [2:0] OFS_WD_STATE = 3'h4;
  localparam logic [2:0] OFS_PREV_A1  = 3'h5;
  localparam logic [2:0] OFS_PREV_A2  = 3'h6;
  localparam logic [2:0] OFS_IMG_RD   = 3'h7;

  // Field positions
  localparam int BIT_RECONFIG  = 0;
  localparam int BIT_WD_RST    = 1;
  localparam int BIT_OVERRIDE  = 0;
  localparam int BIT_IMG_SEL   = 1;
  localparam int BIT_BUSY      = 0;
  localparam int RD_REQ_W      = 4;
  localparam int WD_FIELD_W    = 12;
  localparam int WD_COUNT_W    = 29;
  localparam int STATE_CODE_W  = 4;
  localparam int WD_WORD_W     = 17;
  localparam int PREV_WORD_W   = 8;
  localparam int IMG_WORD_W    = 2;

  // Serial lengths of each upgrade block register
  localparam int          SHIFT_W       = 34;
  localparam logic [5:0]  LEN_WD        = 6'h22;
  localparam logic [5:0]  LEN_PREV      = 6'h08;
  localparam logic [5:0]  LEN_IMG       = 6'h02;

  // Reset values
  localparam logic [31:0] RST_WORD      = 32'h0000_0000;

  // Timing
  localparam int          RQ_PULSE_NS   = 250;
  localparam int          BUSY_MAX_CYC  = 531;

  // Upgrade block register selection
  typedef enum logic [1:0] {
    TGT_WATCHDOG,
    TGT_PREV_A1,
    TGT_PREV_A2,
    TGT_INPUT
  } target_t;

endpackage

// ---- pkg/upg_shift_if.sv ----
// Carrier between the register front-end and the serial shift engine
`timescale 1ns/1ps
interface upg_shift_if;
  import reconfig_ctl_pkg::*;
  logic                start;
  logic                op_write;
  logic [5:0]          nbits;
  logic [SHIFT_W-1:0]  wdata;
  logic [SHIFT_W-1:0]  rdata;
  logic                done;
  logic                tick;
  logic                shift_load_n;
  logic                capt_upd_n;
  logic                serial_in;

  modport ctrl (output start, output op_write, output nbits, output wdata, output tick,
                input rdata, input done, input shift_load_n, input capt_upd_n,
                input serial_in);
  modport eng  (input start, input op_write, input nbits, input wdata, input tick,
                output rdata, output done, output shift_load_n, output capt_upd_n,
                output serial_in);
endinterface

// ---- hw/upg_shift_engine.sv ----
// Serial capture, shift and update engine towards the upgrade block
`timescale 1ns/1ps
module upg_shift_engine
  import reconfig_ctl_pkg::*;
(
  // Clock and reset
  input  wire logic    clk,
  input  wire logic    rst_n,
  // Serial data returned by the upgrade block
  input  wire logic    serial_out,
  // Front-end side
  upg_shift_if.eng     sif
);

  typedef enum logic [2:0] {ENG_IDLE, ENG_CAPTURE, ENG_SHIFT, ENG_UPDATE, ENG_FINISH} eng_t;

  eng_t               st_ff;
  logic [SHIFT_W-1:0] sreg_ff;
  logic [5:0]         cnt_ff;
  logic [5:0]         len_ff;
  logic               wr_ff;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_ff            <= ENG_IDLE;
      sreg_ff          <= '0;
      cnt_ff           <= 6'h00;
      len_ff           <= 6'h00;
      wr_ff            <= 1'b0;
      sif.shift_load_n <= 1'b1;
      sif.capt_upd_n   <= 1'b1;
      sif.serial_in    <= 1'b0;
      sif.done         <= 1'b0;
      sif.rdata        <= '0;
    end else begin
      sif.done <= 1'b0;
      case (st_ff)
        ENG_IDLE: begin
          if (sif.start) begin
            sreg_ff <= sif.wdata;
            cnt_ff  <= sif.nbits;
            len_ff  <= sif.nbits;
            wr_ff   <= sif.op_write;
            st_ff   <= sif.op_write ? ENG_SHIFT : ENG_CAPTURE;
          end
        end
        ENG_CAPTURE: if (sif.tick) begin
          // Parallel capture of the selected register on the next block clock rise
          sif.shift_load_n <= 1'b0;
          sif.capt_upd_n   <= 1'b1;
          st_ff            <= ENG_SHIFT;
        end
        ENG_SHIFT: if (sif.tick) begin
          sif.shift_load_n <= 1'b1;
          sif.serial_in    <= sreg_ff[0];
          sreg_ff          <= {serial_out, sreg_ff[SHIFT_W-1:1]};
          cnt_ff           <= cnt_ff - 6'h01;
          if (cnt_ff == 6'h01) begin
            st_ff <= wr_ff ? ENG_UPDATE : ENG_FINISH;
          end
        end
        ENG_UPDATE: if (sif.tick) begin
          sif.shift_load_n <= 1'b0;
          sif.capt_upd_n   <= 1'b0;
          st_ff            <= ENG_FINISH;
        end
        ENG_FINISH: if (sif.tick) begin
          sif.shift_load_n <= 1'b1;
          sif.capt_upd_n   <= 1'b1;
          sif.rdata        <= sreg_ff >> (6'(SHIFT_W) - len_ff);
          sif.done         <= 1'b1;
          st_ff            <= ENG_IDLE;
        end
        default: st_ff <= ENG_IDLE;
      endcase
    end
  end

endmodule

// ---- hw/reconfig_ctl.sv ----
// Register front-end that drives the remote upgrade block of the device
`timescale 1ns/1ps
module reconfig_ctl
  import reconfig_ctl_pkg::*;
#(
  parameter int CLK_MHZ = 80
)(
  // Clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        NRST,
  // Register port
  input  wire logic [2:0]  ADDRESS,
  input  wire logic        WRITE,
  input  wire logic        READ,
  input  wire logic [31:0] WRITEDATA,
  output logic      [31:0] READDATA,
  // Upgrade block
  output logic             UPGRADE_BLOCK_CLOCK,
  output logic             WATCHDOG_RESTART_N,
  output logic             RECONFIG_REQUEST_N,
  output logic      [1:0]  REGISTER_SELECT,
  output logic             SHIFT_LOAD_N,
  output logic             CAPTURE_UPDATE_N,
  output logic             SERIAL_TO_BLOCK,
  input  wire logic        SERIAL_FROM_BLOCK
);

  localparam int         PULSE_RAW = (RQ_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int         PULSE_CYC = (PULSE_RAW < 1) ? 1 : PULSE_RAW;
  localparam logic [7:0] PULSE_LEN = 8'(PULSE_CYC);

  // Job indices: image write first, then readbacks in offset 2 bit order
  localparam int J_IMG_WR = 0;
  localparam int J_RD_WD  = 1;
  localparam int J_RD_A1  = 2;
  localparam int J_RD_A2  = 3;
  localparam int J_RD_IMG = 4;

  typedef enum logic {SEQ_IDLE, SEQ_RUN} seq_t;

  upg_shift_if sif ();

  logic                   phase_ff;
  logic                   busy_ff;
  logic [4:0]             pend_ff;
  seq_t                   seq_ff;
  logic [2:0]             job_ff;
  logic [IMG_WORD_W-1:0]  img_wval_ff;
  logic [7:0]             rcfg_cnt_ff;
  logic [7:0]             wdr_cnt_ff;
  logic [WD_WORD_W-1:0]   wd_word_ff;
  logic [PREV_WORD_W-1:0] a1_word_ff;
  logic [PREV_WORD_W-1:0] a2_word_ff;
  logic [IMG_WORD_W-1:0]  img_word_ff;
  logic                   start_ff;
  logic                   opw_ff;
  logic [5:0]             nbits_ff;
  logic [SHIFT_W-1:0]     wdata_ff;
  logic                   wr_action;
  logic                   wr_img;
  logic                   wr_rdreq;
  logic [2:0]             nxt_job;

  assign wr_action = WRITE && (ADDRESS == OFS_ACTION);
  assign wr_img    = WRITE && (ADDRESS == OFS_IMG_WR);
  assign wr_rdreq  = WRITE && (ADDRESS == OFS_RD_REQ);

  // Upgrade block clock at half the input rate
  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      phase_ff <= 1'b0;
    end else begin
      phase_ff <= !phase_ff;
    end
  end

  assign UPGRADE_BLOCK_CLOCK = phase_ff;
  assign sif.tick            = phase_ff;

  // Reconfiguration request pulse, dropped while busy
  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      rcfg_cnt_ff        <= 8'h00;
      RECONFIG_REQUEST_N <= 1'b1;
    end else if (wr_action && WRITEDATA[BIT_RECONFIG] && !busy_ff && rcfg_cnt_ff == 8'h00) begin
      rcfg_cnt_ff        <= PULSE_LEN - 8'h01;
      RECONFIG_REQUEST_N <= 1'b0;
    end else if (rcfg_cnt_ff != 8'h00) begin
      rcfg_cnt_ff <= rcfg_cnt_ff - 8'h01;
    end else begin
      RECONFIG_REQUEST_N <= 1'b1;
    end
  end

  // Watchdog restart pulse, accepted even while busy
  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      wdr_cnt_ff         <= 8'h00;
      WATCHDOG_RESTART_N <= 1'b1;
    end else if (wr_action && WRITEDATA[BIT_WD_RST] && wdr_cnt_ff == 8'h00) begin
      wdr_cnt_ff         <= PULSE_LEN - 8'h01;
      WATCHDOG_RESTART_N <= 1'b0;
    end else if (wdr_cnt_ff != 8'h00) begin
      wdr_cnt_ff <= wdr_cnt_ff - 8'h01;
    end else begin
      WATCHDOG_RESTART_N <= 1'b1;
    end
  end

  // Pending jobs; new requests are only taken while idle
  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      pend_ff     <= 5'h00;
      img_wval_ff <= '0;
    end else begin
      if (sif.done) begin
        pend_ff[job_ff] <= 1'b0;
      end
      if (!busy_ff && wr_img) begin
        pend_ff[J_IMG_WR] <= 1'b1;
        img_wval_ff       <= {WRITEDATA[BIT_IMG_SEL], WRITEDATA[BIT_OVERRIDE]};
      end
      if (!busy_ff && wr_rdreq) begin
        pend_ff[J_RD_IMG:J_RD_WD] <= WRITEDATA[RD_REQ_W-1:0];
      end
    end
  end

  // Busy rises after an accepted command and falls once all jobs are done
  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      busy_ff <= 1'b0;
    end else if (!busy_ff && (wr_img || (wr_rdreq && WRITEDATA[RD_REQ_W-1:0] != 4'h0))) begin
      busy_ff <= 1'b1;
    end else if (seq_ff == SEQ_IDLE && pend_ff == 5'h00 && !start_ff) begin
      busy_ff <= 1'b0;
    end
  end

  always_comb begin
    nxt_job = 3'(J_RD_IMG);
    for (int i = J_RD_IMG; i >= 0; i--) begin
      if (pend_ff[i]) begin
        nxt_job = 3'(i);
      end
    end
  end

  // Job sequencer towards the shift engine
  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      seq_ff          <= SEQ_IDLE;
      job_ff          <= 3'h0;
      start_ff        <= 1'b0;
      opw_ff          <= 1'b0;
      nbits_ff        <= 6'h00;
      wdata_ff        <= '0;
      REGISTER_SELECT <= TGT_WATCHDOG;
    end else begin
      start_ff <= 1'b0;
      case (seq_ff)
        SEQ_IDLE: begin
          if (pend_ff != 5'h00 && !start_ff) begin
            job_ff   <= nxt_job;
            start_ff <= 1'b1;
            seq_ff   <= SEQ_RUN;
            opw_ff   <= (nxt_job == 3'(J_IMG_WR));
            wdata_ff <= {{(SHIFT_W-IMG_WORD_W){1'b0}}, img_wval_ff};
            case (nxt_job)
              3'(J_RD_WD): begin
                nbits_ff        <= LEN_WD;
                REGISTER_SELECT <= TGT_WATCHDOG;
              end
              3'(J_RD_A1): begin
                nbits_ff        <= LEN_PREV;
                REGISTER_SELECT <= TGT_PREV_A1;
              end
              3'(J_RD_A2): begin
                nbits_ff        <= LEN_PREV;
                REGISTER_SELECT <= TGT_PREV_A2;
              end
              default: begin
                nbits_ff        <= LEN_IMG;
                REGISTER_SELECT <= TGT_INPUT;
              end
            endcase
          end
        end
        SEQ_RUN: begin
          if (sif.done) begin
            seq_ff <= SEQ_IDLE;
          end
        end
        default: seq_ff <= SEQ_IDLE;
      endcase
    end
  end

  assign sif.start    = start_ff;
  assign sif.op_write = opw_ff;
  assign sif.nbits    = nbits_ff;
  assign sif.wdata    = wdata_ff;

  upg_shift_engine u_engine (
    .clk        (REF_CLK),
    .rst_n      (NRST),
    .serial_out (SERIAL_FROM_BLOCK),
    .sif        (sif)
  );

  assign SHIFT_LOAD_N     = sif.shift_load_n;
  assign CAPTURE_UPDATE_N = sif.capt_upd_n;
  assign SERIAL_TO_BLOCK  = sif.serial_in;

  // Readback words captured from finished reads
  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      wd_word_ff  <= '0;
      a1_word_ff  <= '0;
      a2_word_ff  <= '0;
      img_word_ff <= '0;
    end else if (sif.done) begin
      case (job_ff)
        3'(J_RD_WD): wd_word_ff <= {sif.rdata[WD_COUNT_W+STATE_CODE_W:WD_COUNT_W],
                                    sif.rdata[WD_COUNT_W-1:WD_COUNT_W-WD_FIELD_W]};
        3'(J_RD_A1): a1_word_ff <= sif.rdata[PREV_WORD_W-1:0];
        3'(J_RD_A2): a2_word_ff <= sif.rdata[PREV_WORD_W-1:0];
        3'(J_RD_IMG): img_word_ff <= sif.rdata[IMG_WORD_W-1:0];
        default: img_word_ff <= img_word_ff;
      endcase
    end
  end

  // Read data, one cycle after the read strobe
  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      READDATA <= RST_WORD;
    end else if (READ) begin
      case (ADDRESS)
        OFS_BUSY:     READDATA <= {31'h0000_0000, busy_ff};
        OFS_WD_STATE: READDATA <= {15'h0000, wd_word_ff};
        OFS_PREV_A1:  READDATA <= {24'h00_0000, a1_word_ff};
        OFS_PREV_A2:  READDATA <= {24'h00_0000, a2_word_ff};
        OFS_IMG_RD:   READDATA <= {30'h0000_0000, img_word_ff};
        default:      READDATA <= RST_WORD;
      endcase
    end else begin
      READDATA <= RST_WORD;
    end
  end

  // Helper counters for checking
  logic [9:0] busy_cnt_ff;
  logic [7:0] rlow_cnt_ff;

  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      busy_cnt_ff <= 10'h000;
      rlow_cnt_ff <= 8'h00;
    end else begin
      busy_cnt_ff <= busy_ff ? busy_cnt_ff + 10'h001 : 10'h000;
      rlow_cnt_ff <= !RECONFIG_REQUEST_N ? rlow_cnt_ff + 8'h01 : 8'h00;
    end
  end

  a_reconfig_start: assert property (@(posedge REF_CLK) disable iff (!NRST)
    wr_action && WRITEDATA[BIT_RECONFIG] && !busy_ff && RECONFIG_REQUEST_N
    |=> !RECONFIG_REQUEST_N)
    else $error("reconfiguration request not issued");

  a_restart_when_busy: assert property (@(posedge REF_CLK) disable iff (!NRST)
    wr_action && WRITEDATA[BIT_WD_RST] && busy_ff && WATCHDOG_RESTART_N
    |=> !WATCHDOG_RESTART_N)
    else $error("watchdog restart dropped while busy");

  a_reconfig_drop: assert property (@(posedge REF_CLK) disable iff (!NRST)
    wr_action && WRITEDATA[BIT_RECONFIG] && busy_ff && RECONFIG_REQUEST_N
    |=> RECONFIG_REQUEST_N)
    else $error("reconfiguration accepted while busy");

  a_pulse_length: assert property (@(posedge REF_CLK) disable iff (!NRST)
    $rose(RECONFIG_REQUEST_N) |-> rlow_cnt_ff == PULSE_LEN)
    else $error("request pulse length wrong");

  a_img_busy_rise: assert property (@(posedge REF_CLK) disable iff (!NRST)
    wr_img && !busy_ff |=> busy_ff ##1 pend_ff[J_IMG_WR])
    else $error("busy not raised after image write");

  a_img_ignored: assert property (@(posedge REF_CLK) disable iff (!NRST)
    wr_img && busy_ff |=> $stable(img_wval_ff))
    else $error("image write taken while busy");

  a_read_busy_rise: assert property (@(posedge REF_CLK) disable iff (!NRST)
    wr_rdreq && !busy_ff && WRITEDATA[RD_REQ_W-1:0] != 4'h0
    |=> busy_ff && pend_ff[J_RD_IMG:J_RD_WD] == $past(WRITEDATA[RD_REQ_W-1:0]))
    else $error("readback request not taken");

  a_busy_bound: assert property (@(posedge REF_CLK) disable iff (!NRST)
    busy_cnt_ff <= 10'(BUSY_MAX_CYC))
    else $error("busy held too long");

  a_busy_readback: assert property (@(posedge REF_CLK) disable iff (!NRST)
    READ && ADDRESS == OFS_BUSY |=> READDATA == {31'h0000_0000, $past(busy_ff)})
    else $error("busy word wrong");

  a_cmd_reads_zero: assert property (@(posedge REF_CLK) disable iff (!NRST)
    READ && ADDRESS < OFS_BUSY |=> READDATA == RST_WORD)
    else $error("command offset read not zero");

  a_reserved_zero: assert property (@(posedge REF_CLK) disable iff (!NRST)
    READDATA[31:WD_WORD_W] == 15'h0000)
    else $error("reserved bits not zero");

  a_clock_half: assert property (@(posedge REF_CLK) disable iff (!NRST)
    UPGRADE_BLOCK_CLOCK |=> !UPGRADE_BLOCK_CLOCK ##1 UPGRADE_BLOCK_CLOCK)
    else $error("upgrade clock not half rate");

  a_reset_clear: assert property (@(posedge REF_CLK)
    !NRST |=> !busy_ff && READDATA == RST_WORD && RECONFIG_REQUEST_N)
    else $error("reset did not clear state");

  c_image_write: cover property (@(posedge REF_CLK) disable iff (!NRST)
    wr_img && !busy_ff ##1 busy_ff ##[1:100] !busy_ff);

  c_all_reads: cover property (@(posedge REF_CLK) disable iff (!NRST)
    wr_rdreq && !busy_ff && WRITEDATA[RD_REQ_W-1:0] == 4'hf ##[1:531] !busy_ff);

  c_reconfig: cover property (@(posedge REF_CLK) disable iff (!NRST)
    $rose(RECONFIG_REQUEST_N));

endmodule

// ---- sim/upg_block_model.sv ----
// Behavioural model of the upgrade block behind the serial pins
`timescale 1ns/1ps
module upg_block_model
  import reconfig_ctl_pkg::*;
(
  // Clocks
  input  wire logic               clk,
  input  wire logic               blk_clk,
  // Serial pins
  input  wire logic [1:0]         sel,
  input  wire logic               shift_load_n,
  input  wire logic               capt_upd_n,
  input  wire logic               din,
  output logic                    dout,
  // Contents
  input  wire logic [SHIFT_W-1:0] wd_val,
  input  wire logic [7:0]         a1_val,
  input  wire logic [7:0]         a2_val,
  output logic      [1:0]         input_reg
);
  logic [SHIFT_W-1:0] sh;
  logic [SHIFT_W-1:0] nxt_sh;
  logic [5:0]         len;

  always_comb begin
    case (sel)
      2'h0:       len = LEN_WD;
      2'h1, 2'h2: len = LEN_PREV;
      default:    len = LEN_IMG;
    endcase
  end

  assign dout = sh[0];

  initial begin
    sh = '0;
    input_reg = 2'h0;
  end

  // Acts on each rising edge of the upgrade clock, so the first shift sees captured data
  always @(posedge clk) begin
    if (!blk_clk) begin
      if (!shift_load_n && capt_upd_n) begin
        case (sel)
          2'h0:    sh <= wd_val;
          2'h1:    sh <= {26'h0, a1_val};
          2'h2:    sh <= {26'h0, a2_val};
          default: sh <= {32'h0, input_reg};
        endcase
      end else if (shift_load_n) begin
        nxt_sh = sh >> 1;
        nxt_sh[len - 6'h1] = din;
        sh <= nxt_sh;
      end else if (sel == 2'h3) begin
        input_reg <= sh[1:0];
      end
    end
  end
endmodule

// ---- sim/tb_dual_image_reconfig_control.sv ----
// Self-checking bench for the reconfiguration control front-end
`timescale 1ns/1ps
module tb_dual_image_reconfig_control;
  import reconfig_ctl_pkg::*;
  localparam int CLK_MHZ   = 25;
  localparam int PULSE_CYC = (RQ_PULSE_NS * CLK_MHZ + 999) / 1000;

  logic               ref_clk   = 1'b0;
  logic               nrst      = 1'b0;
  logic [2:0]         address   = 3'h0;
  logic               write     = 1'b0;
  logic               read      = 1'b0;
  logic [31:0]        writedata = 32'h0;
  logic [31:0]        readdata;
  logic               ubc;
  logic               wdr_n;
  logic               cfg_n;
  logic [1:0]         rsel;
  logic               sl_n;
  logic               cu_n;
  logic               s_to;
  logic               s_from;
  logic [1:0]         input_reg;
  logic [SHIFT_W-1:0] wd_val    = '0;
  logic [7:0]         a1_val    = 8'h0;
  logic [7:0]         a2_val    = 8'h0;
  logic [1:0]         img       = 2'h0;
  logic [63:0]        rnd;
  logic [32:0]        e;
  logic [31:0]        last_rd   = 32'h0;
  logic               rd_pend   = 1'b0;
  logic               ubc_q     = 1'b0;
  logic [32:0]        exp_rd[$];
  int                 exp_cfg[$];
  int                 exp_wdr[$];
  int                 cfg_len   = 0;
  int                 wdr_len   = 0;
  int                 run_cyc   = 0;
  int                 rst_cyc   = 0;
  int                 failures  = 0;
  int                 num_checks = 0;
  integer             seed      = 28;

  always #20 ref_clk = ~ref_clk;

  reconfig_ctl #(.CLK_MHZ(CLK_MHZ)) dut (
    .REF_CLK(ref_clk), .NRST(nrst), .ADDRESS(address), .WRITE(write), .READ(read),
    .WRITEDATA(writedata), .READDATA(readdata), .UPGRADE_BLOCK_CLOCK(ubc),
    .WATCHDOG_RESTART_N(wdr_n), .RECONFIG_REQUEST_N(cfg_n), .REGISTER_SELECT(rsel),
    .SHIFT_LOAD_N(sl_n), .CAPTURE_UPDATE_N(cu_n), .SERIAL_TO_BLOCK(s_to),
    .SERIAL_FROM_BLOCK(s_from)
  );

  upg_block_model blk (
    .clk(ref_clk), .blk_clk(ubc), .sel(rsel), .shift_load_n(sl_n), .capt_upd_n(cu_n),
    .din(s_to), .dout(s_from), .wd_val(wd_val), .a1_val(a1_val), .a2_val(a2_val),
    .input_reg(input_reg)
  );

  task automatic check(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'b1) begin
      failures++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask

  task automatic complete_run();
    if (failures == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Monitor: reads, pulse lengths, upgrade clock and reset state
  always @(posedge ref_clk) begin
    if (!nrst) begin
      rst_cyc++;
      run_cyc = 0;
      cfg_len = 0;
      wdr_len = 0;
      if (rst_cyc >= 2) check(cfg_n === 1'b1 && wdr_n === 1'b1 && readdata === 32'h0,
                              "state during reset");
    end else begin
      rst_cyc = 0;
      run_cyc++;
      if (run_cyc >= 3) check(ubc !== ubc_q, "upgrade clock not toggling");
      if (rd_pend) begin
        e = exp_rd.pop_front();
        last_rd = readdata;
        if (e[32]) check(readdata === e[31:0], "read data mismatch");
      end
      if (cfg_n === 1'b0) cfg_len++;
      else if (cfg_len != 0) begin
        check(exp_cfg.size() != 0 && exp_cfg.pop_front() == cfg_len, "reconfig pulse");
        cfg_len = 0;
      end
      if (wdr_n === 1'b0) wdr_len++;
      else if (wdr_len != 0) begin
        check(exp_wdr.size() != 0 && exp_wdr.pop_front() == wdr_len, "restart pulse");
        wdr_len = 0;
      end
    end
    rd_pend = read;
    ubc_q = ubc;
  end

  task automatic wr(input logic [2:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    #1;
    address = a;
    writedata = d;
    write = 1'b1;
    @(posedge ref_clk);
    #1;
    write = 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, input logic chk, input logic [31:0] x);
    exp_rd.push_back({chk, x});
    @(posedge ref_clk);
    #1;
    address = a;
    read = 1'b1;
    @(posedge ref_clk);
    #1;
    read = 1'b0;
    @(posedge ref_clk);
    #1;
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      rd(OFS_BUSY, 1'b0, 32'h0);
      n++;
    end while (last_rd[BIT_BUSY] !== 1'b0 && n < 200);
    check(last_rd === 32'h0 && n * 3 <= 540, "busy held too long");
  endtask

  function automatic logic [31:0] exp_word(input int k);
    case (k)
      0:       return {15'h0, wd_val[33:30], wd_val[29], wd_val[28:17]};
      1:       return {24'h0, a1_val};
      2:       return {24'h0, a2_val};
      default: return {30'h0, img};
    endcase
  endfunction

  task automatic new_contents();
    rnd = {$random(seed), $random(seed)};
    wd_val = rnd[SHIFT_W-1:0];
    a1_val = rnd[41:34];
    a2_val = rnd[49:42];
  endtask

  initial begin
    repeat (10) @(posedge ref_clk);
    #1;
    nrst = 1'b1;
    for (int a = 0; a < 4; a++) rd(a[2:0], 1'b1, 32'h0);
    wr(OFS_ACTION, 32'h0);
    exp_cfg.push_back(PULSE_CYC);
    wr(OFS_ACTION, 32'hffff_fff1);
    repeat (PULSE_CYC + 4) @(posedge ref_clk);
    exp_wdr.push_back(PULSE_CYC);
    exp_cfg.push_back(PULSE_CYC);
    wr(OFS_ACTION, 32'h3);
    repeat (PULSE_CYC + 4) @(posedge ref_clk);
    for (int i = 0; i < 4; i++) begin
      img = i[1:0];
      new_contents();
      wr(OFS_IMG_WR, {rnd[63:34], img});
      rd(OFS_BUSY, 1'b1, 32'h1);
      wait_idle();
      wr(OFS_RD_REQ, {rnd[63:36], 4'hf});
      exp_wdr.push_back(PULSE_CYC);
      wr(OFS_ACTION, 32'h3);
      wr(OFS_IMG_WR, {30'h0, ~img});
      rd(OFS_BUSY, 1'b1, 32'h1);
      wait_idle();
      for (int k = 0; k < 4; k++) rd(OFS_WD_STATE + k[2:0], 1'b1, exp_word(k));
      new_contents();
      wr(OFS_RD_REQ, 32'h1 << i);
      wait_idle();
      rd(OFS_WD_STATE + i[2:0], 1'b1, exp_word(i));
    end
    wr(OFS_RD_REQ, 32'h1);
    wr(OFS_ACTION, 32'h2);
    nrst = 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
    nrst = 1'b1;
    rd(OFS_BUSY, 1'b1, 32'h0);
    rd(OFS_WD_STATE, 1'b1, 32'h0);
    rd(OFS_IMG_RD, 1'b1, 32'h0);
    repeat (PULSE_CYC + 4) @(posedge ref_clk);
    check(exp_cfg.size() == 0 && exp_wdr.size() == 0, "missing pulse");
    complete_run();
  end

  initial begin
    #(40 * 60000);
    failures++;
    complete_run();
  end
endmodule
